//--- rtl/nested_interrupt_controller.sv
/*
 * Nested interrupt controller for a VLIW core: latches requests, gates them by
 * mask, arbitrates by priority, offers the winner to the program sequencer
 * with its vector and a pipeline-cancel indication, and tracks nesting.
 * Assumes the sequencer acknowledges an offer and reports each return from a
 * service routine with a one-cycle pulse, all synchronous to REF_CLK.
 */
// Overview of operation
// - Nested or run-to-completion servicing, selectable.
// - Each type owns a vector table entry.
// - Each type has a latch bit; every type but the exception has a mask bit.
// - Fixed sensitivities; external lines software selectable.
// - Software exception cancels whole pipeline.
// - Hardware interrupt lets pipeline finish.
// - Higher priority preempts lower priority routine.
`timescale 1ns/1ps
module nested_interrupt_controller
(
	input  wire logic                           REF_CLK,
	input  wire logic                           RESET,
	input  wire logic                           CE,
	input  wire logic                           SW_EXC,
	input  wire logic [nic_pkg::NUM_EXT-1:0]    EXTERNAL_REQUEST_LINES,
	input  wire logic [nic_pkg::NUM_EXT-1:0]    EXT_EDGE,
	input  wire logic [nic_pkg::NUM_HW-1:0]     HW_REQ,
	input  wire logic [nic_pkg::NUM_TYPES-1:0]  MASK,
	input  wire logic                           NEST_EN,
	input  wire logic                           VT_WE,
	input  wire logic [nic_pkg::ID_W-1:0]       VT_IDX,
	input  wire logic [nic_pkg::ADDR_W-1:0]     VT_ADDR,
	input  wire logic                           TAKE_ACK,
	input  wire logic                           RETURN_DONE,
	output logic                                TAKE_VALID,
	output logic      [nic_pkg::ID_W-1:0]       TAKE_ID,
	output logic      [nic_pkg::ADDR_W-1:0]     TAKE_VECTOR,
	output logic                                FLUSH_PIPE,
	output logic      [nic_pkg::NUM_TYPES-1:0]  LATCH,
	output logic      [nic_pkg::NUM_TYPES-1:0]  IN_SERVICE
);

	import nic_pkg::*;

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RESET);

	typedef enum logic {ST_IDLE, ST_OFFER} offer_state_e;

	offer_state_e              state;
	logic [NUM_TYPES-1:0]      raw;
	logic [NUM_TYPES-1:0]      raw_q;
	logic [NUM_TYPES-1:0]      edge_sel;
	logic [NUM_TYPES-1:0]      set_vec;
	logic [NUM_TYPES-1:0]      latch_q;
	logic [NUM_TYPES-1:0]      svc_q;
	logic [NUM_TYPES-1:0]      eligible;
	logic [NUM_TYPES-1:0]      take_bit;
	logic [NUM_TYPES-1:0]      ret_bit;
	logic [ADDR_W-1:0]         vector_table [NUM_TYPES];
	logic [ADDR_W-1:0]         vt_sel;
	logic                      cand_any;
	logic [ID_W-1:0]           cand_id;
	logic                      svc_any;
	logic [ID_W-1:0]           cur_id;
	logic                      allowed;
	logic                      take_fire;

	////////////////////////////////////////////////////////////////////////////////
	// Request assembly and sensitivity.

	assign raw      = {HW_REQ, EXTERNAL_REQUEST_LINES, SW_EXC};
	assign edge_sel = {HW_EDGE_FIXED, EXT_EDGE, 1'b1};

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			raw_q <= VEC_ZERO;
		end else if (CE) begin
			raw_q <= raw;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-type latch, in-service and vector storage.

	assign take_fire = CE && (state == ST_OFFER) && TAKE_ACK;

	genvar g;
	generate
		for (g = 0; g < NUM_TYPES; g++) begin : g_type
			assign set_vec[g]  = edge_sel[g] ? (raw[g] & ~raw_q[g]) : raw[g];
			assign take_bit[g] = take_fire && (TAKE_ID == ID_W'(g));
			assign ret_bit[g]  = RETURN_DONE && svc_any && (cur_id == ID_W'(g));

			// A new event wins over the clear caused by its own acknowledge.
			always_ff @(posedge REF_CLK or posedge RESET) begin
				if (RESET) begin
					latch_q[g] <= 1'b0;
				end else if (CE) begin
					latch_q[g] <= set_vec[g] | (latch_q[g] & ~take_bit[g]);
				end
			end

			always_ff @(posedge REF_CLK or posedge RESET) begin
				if (RESET) begin
					svc_q[g] <= 1'b0;
				end else if (CE) begin
					svc_q[g] <= take_bit[g] | (svc_q[g] & ~ret_bit[g]);
				end
			end

			always_ff @(posedge REF_CLK or posedge RESET) begin
				if (RESET) begin
					vector_table[g] <= VECTOR_RESET;
				end else if (CE && VT_WE && (VT_IDX == ID_W'(g))) begin
					vector_table[g] <= VT_ADDR;
				end
			end

			AST_EDGE_NO_RELATCH: assert property (CE && edge_sel[g] && raw[g] && raw_q[g] && !latch_q[g]
				|=> !latch_q[g])
				else $error("Edge-sensitive type relatched on a held level.");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Arbitration.

	// Exceptions cannot be masked; every other type needs its mask bit.
	assign eligible = latch_q & (MASK | {{(NUM_TYPES-1){1'b0}}, 1'b1});

	irq_priority_pick u_pick_pending (
		.vec (eligible),
		.any (cand_any),
		.idx (cand_id)
	);

	irq_priority_pick u_pick_service (
		.vec (svc_q),
		.any (svc_any),
		.idx (cur_id)
	);

	// Lower index is higher priority; nesting only admits a strictly higher one.
	assign allowed = cand_any && (!svc_any || (NEST_EN && (cand_id < cur_id)));
	assign vt_sel  = vector_table[cand_id];

	////////////////////////////////////////////////////////////////////////////////
	// Offer to the program sequencer.

	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			state <= ST_IDLE;
		end else if (CE) begin
			case (state)
				ST_IDLE: begin
					if (allowed) begin
						state <= ST_OFFER;
					end
				end
				ST_OFFER: begin
					if (TAKE_ACK) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// The winner is frozen while offered so the sequencer sees a stable request.
	always_ff @(posedge REF_CLK or posedge RESET) begin
		if (RESET) begin
			TAKE_ID     <= '0;
			TAKE_VECTOR <= VECTOR_RESET;
			FLUSH_PIPE  <= 1'b0;
		end else if (CE && (state == ST_IDLE) && allowed) begin
			TAKE_ID     <= cand_id;
			TAKE_VECTOR <= vt_sel;
			FLUSH_PIPE  <= (cand_id == SW_EXC_ID);
		end
	end

	assign TAKE_VALID = (state == ST_OFFER);
	assign LATCH      = latch_q;
	assign IN_SERVICE = svc_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	sequence s_launch;
		CE && (state == ST_IDLE) && allowed;
	endsequence

	sequence s_fire;
		TAKE_VALID && TAKE_ACK && CE;
	endsequence

	AST_LAUNCH_VECTOR: assert property (s_launch |=> TAKE_VALID && (TAKE_VECTOR == $past(vt_sel)))
		else $error("Offered vector does not match the table entry.");

	AST_LAUNCH_GATED: assert property (s_launch |-> latch_q[cand_id] && (MASK[cand_id] || cand_id == SW_EXC_ID))
		else $error("Offered type was not latched and unmasked.");

	AST_FLUSH_EXC: assert property (TAKE_VALID && (TAKE_ID == SW_EXC_ID) |-> FLUSH_PIPE)
		else $error("Software exception offered without pipeline cancel.");

	AST_NO_FLUSH_HW: assert property (TAKE_VALID && (TAKE_ID != SW_EXC_ID) |-> !FLUSH_PIPE)
		else $error("Hardware interrupt offered with pipeline cancel.");

	AST_NONNEST_HOLD: assert property ((state == ST_IDLE) && !NEST_EN && svc_any |=> !TAKE_VALID)
		else $error("Offer made during a routine with nesting disabled.");

	AST_PREEMPT_PRIO: assert property ($rose(TAKE_VALID) && $past(svc_any) |-> TAKE_ID < $past(cur_id))
		else $error("Preempting type is not of higher priority.");

	AST_MASKED_KEPT: assert property (CE && !take_fire |=> (latch_q & $past(latch_q)) == $past(latch_q))
		else $error("Latched request lost without being taken.");

	AST_FIRE_SERVICE: assert property (s_fire |=> IN_SERVICE[$past(TAKE_ID)] && !TAKE_VALID)
		else $error("Taken type not marked in service.");

	AST_UNMASK_SERVED: assert property (CE && (state == ST_IDLE) && !svc_any && (eligible != VEC_ZERO)
		|=> TAKE_VALID)
		else $error("Unmasked pending request not offered.");

endmodule : nested_interrupt_controller

//--- rtl/nic_pkg.sv
/*
 * Constants for the nested interrupt controller: type numbering, widths,
 * fixed sensitivities and reset values.
 * Assumes the core clock and core reset are shared by every user of it.
 */
package nic_pkg;

	localparam int unsigned NUM_TYPES = 16;
	localparam int unsigned ID_W      = 4;
	localparam int unsigned ADDR_W    = 32;
	localparam int unsigned NUM_EXT   = 4;
	localparam int unsigned NUM_HW    = 11;

	// Type 0 is the software exception, 1..4 the external lines, 5..15 on-chip sources.
	localparam logic [ID_W-1:0] SW_EXC_ID = 4'h0;
	localparam logic [ID_W-1:0] EXT_BASE  = 4'h1;

	// Fixed sensitivity of the on-chip sources, bit set means edge-sensitive.
	localparam logic [NUM_HW-1:0] HW_EDGE_FIXED = 11'h0_0F0;

	localparam logic [ADDR_W-1:0]    VECTOR_RESET = 32'h0000_0000;
	localparam logic [NUM_TYPES-1:0] VEC_ZERO     = 16'h0000;

endpackage : nic_pkg

//--- rtl/irq_priority_pick.sv
/*
 * Priority picker: reports whether any bit of a vector is set and the index
 * of the lowest set bit, which is the highest priority.
 * Assumes nothing of its surroundings; purely combinational.
 */
`timescale 1ns/1ps
module irq_priority_pick (
	input  wire logic [nic_pkg::NUM_TYPES-1:0] vec,
	output logic                               any,
	output logic [nic_pkg::ID_W-1:0]           idx
);

	import nic_pkg::*;

	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = NUM_TYPES - 1; i >= 0; i--) begin
			if (vec[i]) begin
				any = 1'b1;
				idx = ID_W'(i);
			end
		end
	end

endmodule : irq_priority_pick

//--- verification/seq_model.sv
/*
 * Program sequencer stand-in: acknowledges each interrupt offer after a set delay.
 * Assumes it shares REF_CLK with the controller and drives just after the falling edge.
 */
`timescale 1ns/1ps
module seq_model (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       take_valid,
	input  wire logic [3:0] delay,
	output logic            take_ack
);
	int unsigned waited;
	// The acknowledge is held until the offer drops after the accepting edge.
	always_ff @(negedge clk) begin
		if (reset || !take_valid) begin
			take_ack <= 1'b0;
			waited   <= 0;
		end else if (waited >= delay) begin
			take_ack <= 1'b1;
		end else begin
			waited <= waited + 1;
		end
	end
endmodule : seq_model

//--- verification/nested_interrupt_controller_tb.sv
/*
 * Self-checking bench for the nested interrupt controller.
 * Assumes the sequencer model answers offers; the bench drives sources and returns.
 */
`timescale 1ns/1ps
module nested_interrupt_controller_tb;
	import nic_pkg::*;
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("mismatch %s expected %h seen %h", nm, e, g); end end
	logic                 clk, rst, sw, nest, vwe, ack, ret, tvalid, flush;
	logic [NUM_EXT-1:0]   ext, edg;
	logic [NUM_HW-1:0]    hw;
	logic [NUM_TYPES-1:0] mask, latch, insvc;
	logic [ID_W-1:0]      vidx, tid;
	logic [ADDR_W-1:0]    vaddr, tvec;
	logic [3:0]           dly;
	int                   n_fail = 0;
	int                   checked = 0;
	////////////////////////////////////////////////////////////////////////////////
	nested_interrupt_controller DUT (.REF_CLK(clk), .RESET(rst), .CE(1'b1), .SW_EXC(sw),
		.EXTERNAL_REQUEST_LINES(ext), .EXT_EDGE(edg), .HW_REQ(hw), .MASK(mask), .NEST_EN(nest),
		.VT_WE(vwe), .VT_IDX(vidx), .VT_ADDR(vaddr), .TAKE_ACK(ack), .RETURN_DONE(ret),
		.TAKE_VALID(tvalid), .TAKE_ID(tid), .TAKE_VECTOR(tvec), .FLUSH_PIPE(flush),
		.LATCH(latch), .IN_SERVICE(insvc));
	seq_model seq (.clk(clk), .reset(rst), .take_valid(tvalid), .delay(dly), .take_ack(ack));
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick
	task vt_write(input logic [ID_W-1:0] id, input logic [ADDR_W-1:0] a);
		vwe = 1'b1;
		vidx = id;
		vaddr = a;
		tick(1);
		vwe = 1'b0;
	endtask : vt_write
	task ret_pulse();
		ret = 1'b1;
		tick(1);
		ret = 1'b0;
		tick(1);
	endtask : ret_pulse
	// Waits for an offer, judges it, then waits until the sequencer has taken it.
	task take(input logic [ID_W-1:0] id, input logic f, input logic [ADDR_W-1:0] v);
		int i;
		i = 0;
		while (tvalid !== 1'b1 && i < 20) begin
			tick(1);
			i++;
		end
		`CHK("take_valid", 1'b1, tvalid)
		`CHK("take_id", id, tid)
		`CHK("vector", v, tvec)
		`CHK("flush", f, flush)
		i = 0;
		while (insvc[id] !== 1'b1 && i < 20) begin
			tick(1);
			i++;
		end
		`CHK("in_service", 1'b1, insvc[id])
	endtask : take
	task complete_run();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : complete_run
	////////////////////////////////////////////////////////////////////////////////
	task t_external();
		vt_write(4'h1, 32'h0000_1100);
		edg[0] = 1'b1;
		mask[1] = 1'b1;
		ext[0] = 1'b1;
		take(4'h1, 1'b0, 32'h0000_1100);
		tick(3);
		`CHK("edge_hold", 1'b0, latch[1])
		ext[0] = 1'b0;
		ret_pulse();
		`CHK("returned", 16'h0000, insvc)
		$display("test external done");
	endtask : t_external
	task t_exception();
		dly = 4'h3;
		vt_write(4'h0, 32'h0000_0A00);
		sw = 1'b1;
		tick(1);
		sw = 1'b0;
		take(4'h0, 1'b1, 32'h0000_0A00);
		ret_pulse();
		dly = 4'h0;
		$display("test exception done");
	endtask : t_exception
	task t_masked();
		hw[0] = 1'b1;
		tick(1);
		hw[0] = 1'b0;
		tick(4);
		`CHK("masked_latch", 1'b1, latch[5])
		`CHK("masked_offer", 1'b0, tvalid)
		mask[5] = 1'b1;
		take(4'h5, 1'b0, VECTOR_RESET);
		$display("test masked done");
	endtask : t_masked
	task t_nested();
		nest = 1'b1;
		mask[2] = 1'b1;
		ext[1] = 1'b1;
		take(4'h2, 1'b0, VECTOR_RESET);
		`CHK("nest_stack", 16'h0024, insvc)
		ext[1] = 1'b0;
		tick(1);
		`CHK("level_hold", 1'b1, latch[2])
		nest = 1'b0;
		ret_pulse();
		tick(3);
		`CHK("no_preempt", 1'b0, tvalid)
		ret_pulse();
		take(4'h2, 1'b0, VECTOR_RESET);
		ret_pulse();
		$display("test nested done");
	endtask : t_nested
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(25 * 3000);
		n_fail++;
		complete_run();
	end
	initial begin
		rst = 1'b1;
		sw = 1'b0;
		nest = 1'b0;
		vwe = 1'b0;
		ret = 1'b0;
		ext = '0;
		edg = '0;
		hw = '0;
		mask = '0;
		vidx = '0;
		vaddr = '0;
		dly = 4'h0;
		tick(10);
		rst = 1'b0;
		`CHK("reset_latch", VEC_ZERO, latch)
		`CHK("reset_offer", 1'b0, tvalid)
		t_external();
		t_exception();
		t_masked();
		t_nested();
		complete_run();
	end
endmodule : nested_interrupt_controller_tb
